// ==== bench/clic_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************
// Host processor model
// ****************
module clic_host (
    // Clock
    input  wire logic       core_clk,
    // Host port
    output logic            reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    logic nib = 1'b0;
    initial begin
        reg_addr  = 1'b0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // Released data turns to the inverse so stale bytes never look valid
    task automatic cyc(input logic rs, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge core_clk);
        reg_addr  <= rs;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~d;
        #1 q = reg_rdata;
    endtask
    task automatic xfer(input logic rs, input logic [7:0] d, input logic w, output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (nib) begin
            cyc(rs, {d[7:4], 4'h0}, w, h);
            cyc(rs, {d[3:0], 4'h0}, w, l);
            q = {h[7:4], l[7:4]};
        end else begin
            cyc(rs, d, w, q);
        end
    endtask
    task automatic status(output logic [7:0] q);
        xfer(1'b0, 8'h00, 1'b0, q);
    endtask
    // Busy is polled before every write and data read made through wr and rd
    task automatic poll();
        logic [7:0] q;
        status(q);
        while (q[7] !== 1'b0) status(q);
    endtask
    task automatic wr(input logic rs, input logic [7:0] d);
        logic [7:0] q;
        poll();
        xfer(rs, d, 1'b1, q);
    endtask
    task automatic rd(input logic rs, output logic [7:0] q);
        poll();
        xfer(rs, 8'h00, 1'b0, q);
    endtask
endmodule // clic_host

`default_nettype wire

// ==== bench/test_char_lcd_instruction_core.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_char_lcd_instruction_core;
    import clic_pkg::*;
    logic             core_clk;
    logic             sys_rst;
    logic             extension_driver_pin;
    logic             reg_addr, reg_wr, reg_rd;
    logic [7:0]       reg_wdata, reg_rdata, q, d;
    clic_disp_t       disp;
    int               err_total, checks, cyc_n, seed, i;
    logic [7:0]       mem[$];

    clic_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    clic_core #(.EXEC_CYCLES(6), .INV_CYCLES(8)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .extension_driver_pin(extension_driver_pin), .disp(disp));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Address counter as seen through the status read
    task automatic ac(input logic [6:0] e);
        host.status(q);
        chk({1'b0, q[6:0]}, {1'b0, e});
    endtask
    // Hang guard, far above the length of the sequence
    always @(posedge core_clk) begin
        cyc_n++;
        if (cyc_n >= 20000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        seed = 21;
        sys_rst = 1'b1;
        extension_driver_pin = 1'b0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        host.status(q);
        chk(q, 8'h00);
        chk(disp.bus_width_sel, 1);
        host.wr(0, 8'h0F);
        chk(disp.font_width_sel, 0);
        host.wr(0, 8'h3C);
        host.wr(0, 8'h0F);
        host.status(q);
        chk(q[7], 1);
        host.wr(0, 8'h38);
        chk(disp.busy_flag, 1);
        host.xfer(0, 8'h93, 1'b1, q);
        ac(7'h00);
        chk(disp.font_width_sel, 1);
        chk(disp.cell_width, 6);
        chk(disp.frame_rate_5_6, 1);
        chk(disp.cursor_attr_ignored, 1);
        chk(disp.line_mode, LM_FOUR);
        chk(disp.rom_left_blank, 1);
        q[0] = disp.invert_phase;
        repeat (8) @(posedge core_clk);
        #1 chk(disp.invert_phase, !q[0]);
        host.wr(0, 8'h93);
        host.wr(0, 8'h14);
        ac(7'h20);
        host.wr(0, 8'h3C);
        host.wr(0, 8'h0E);
        host.wr(0, 8'h38);
        chk(disp.line_mode, LM_TWO);
        host.wr(0, 8'hA7);
        host.wr(0, 8'h14);
        ac(7'h40);
        host.wr(0, 8'h10);
        ac(7'h27);
        host.wr(0, 8'h1C);
        ac(7'h27);
        chk(disp.disp_offset, 39);
        host.wr(0, 8'h18);
        chk(disp.disp_offset, 0);
        host.wr(0, 8'h80);
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            mem.push_back(d);
            host.wr(1, d);
        end
        ac(7'h04);
        host.wr(0, 8'h80);
        for (i = 0; i < 4; i++) begin
            host.rd(1, q);
            chk(q, mem[i]);
        end
        host.wr(0, 8'h45);
        ac(7'h05);
        host.wr(1, 8'hA5);
        host.wr(0, 8'h45);
        host.rd(1, q);
        chk(q, 8'hA5);
        host.wr(0, 8'h3A);
        chk(disp.ram_blink_en, 0);
        host.wr(0, 8'h3E);
        chk(disp.ram_blink_en, 0);
        host.wr(0, 8'h3E);
        chk(disp.ram_blink_en, 1);
        host.wr(0, 8'h7E);
        ac(7'h0E);
        host.wr(1, 8'h5A);
        host.wr(0, 8'h7E);
        host.rd(1, q);
        chk(q, 8'h5A);
        host.wr(0, 8'hB5);
        chk(disp.scroll_dots, 48);
        host.wr(0, 8'hAF);
        chk(disp.scroll_dots, 47);
        host.wr(0, 8'h13);
        chk(disp.scroll_lines[1:0], 1);
        host.wr(0, 8'h3D);
        chk(disp.low_power_active, 1);
        chk(disp.clk_div, 2);
        @(posedge core_clk);
        extension_driver_pin <= 1'b1;
        @(posedge core_clk);
        #1 chk(disp.low_power_active, 0);
        host.wr(0, 8'h38);
        host.wr(0, 8'h28);
        host.nib = 1'b1;
        chk(disp.bus_width_sel, 0);
        host.wr(0, 8'h8A);
        host.wr(1, 8'hC3);
        host.wr(0, 8'h8A);
        host.rd(1, q);
        chk(q, 8'hC3);
        ac(7'h0B);
        stop_test();
    end
endmodule // test_char_lcd_instruction_core

`default_nettype wire

// ==== rtl/clic_core.sv ====
// How it works
// R1 - Extension bits written only with extension on
// R2 - Six-dot cells, blank ROM left dot, slower frames
// R3 - Inverting cursor toggles every 370 ms
// R4 - Four-line bit overrides line-count bit
// R5 - Shift codes: cursor left/right, display left/right
// R6 - Cursor wraps to next line at line end
// R7 - Display shift is horizontal, lines never mix
// R8 - Shift instruction clears extension enable
// R9 - Display shift keeps address; low power blocks
// R10 - Scroll enables map to lines per mode
// R11 - Eight-bit or two-nibble transfers
// R12 - Blink, low power, icon address need extension
// R13 - Blink enable lets font and icon blink
// R14 - Low power divides clock, lengthens execution
// R15 - Font RAM address set, six bits
// R16 - Icon RAM address set, four bits
// R17 - Character addresses follow the line mode
// R18 - Scroll quantity in dots, saturates at 48
// R19 - Status read gives busy and address
// R20 - Host polls busy before next write
// R21 - Data write stores, steps, may shift display
// R22 - Data read returns prefetched byte, steps address
// R23 - Shift instruction decoded, executes within 37 us, or 74 or 148 us in low power
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "clic_defs.svh"

module clic_core #(
    parameter int EXEC_CYCLES = `CLIC_EXEC_CYCLES,
    parameter int INV_CYCLES  = `CLIC_INV_CYCLES
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    // Host port: reg_addr selects instruction (0) or data (1)
    input  wire logic               reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // Pins
    input  wire logic               extension_driver_pin,
    // Display path controls
    output var clic_pkg::clic_disp_t disp
);
    import clic_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [6:0] clic_step(input logic [6:0] a, input logic up,
                                             input clic_line_t lm, input clic_ram_t rs);
        logic [6:0] r;
        r = a;
        unique case (rs)
            RS_CG:  r = {1'b0, up ? 6'(a[5:0] + 6'h01) : 6'(a[5:0] - 6'h01)};
            RS_SEG: r = {3'h0, up ? 4'(a[3:0] + 4'h1) : 4'(a[3:0] - 4'h1)};
            default: begin
                unique case (lm)
                    LM_ONE: begin
                        if (up) begin
                            r = (a >= `CLIC_ONE_END) ? 7'h00 : 7'(a + 7'h01);
                        end else begin
                            r = (a == 7'h00) ? `CLIC_ONE_END : 7'(a - 7'h01);
                        end
                    end
                    LM_TWO: begin
                        if (up) begin
                            r = (a == `CLIC_TWO_L1_END) ? `CLIC_TWO_L2_BEG :
                                (a == `CLIC_TWO_L2_END) ? 7'h00 : 7'(a + 7'h01);
                        end else begin
                            r = (a == `CLIC_TWO_L2_BEG) ? `CLIC_TWO_L1_END :
                                (a == 7'h00) ? `CLIC_TWO_L2_END : 7'(a - 7'h01);
                        end
                    end
                    LM_FOUR: begin
                        if (up) begin
                            r = (a[4:0] == `CLIC_FOUR_END) ? {2'(a[6:5] + 2'h1), 5'h00} : 7'(a + 7'h01);
                        end else begin
                            r = (a[4:0] == 5'h00) ? {2'(a[6:5] - 2'h1), `CLIC_FOUR_END} : 7'(a - 7'h01);
                        end
                    end
                endcase
            end
        endcase
        return r;
    endfunction

    // Offset is taken modulo one line, so no line ever pans into another
    function automatic logic [6:0] clic_pan(input logic [6:0] o, input logic left, input clic_line_t lm);
        logic [6:0] len;
        len = (lm == LM_ONE) ? `CLIC_LEN_ONE : (lm == LM_TWO) ? `CLIC_LEN_TWO : `CLIC_LEN_FOUR;
        if (left) begin
            return (7'(o + 7'h01) >= len) ? 7'h00 : 7'(o + 7'h01);
        end
        return (o == 7'h00 || o >= len) ? 7'(len - 7'h01) : 7'(o - 7'h01);
    endfunction

    function automatic logic [7:0] clic_ram_read(input clic_state_t s, input clic_ram_t sel, input logic [6:0] a);
        unique case (sel)
            RS_CG:   return s.user_font_ram[a[5:0]];
            RS_SEG:  return s.icon_ram[a[3:0]];
            default: return s.char_code_ram[a];
        endcase
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    clic_state_t st_r;
    clic_state_t st_nxt;
    clic_line_t  lm;
    logic        busy;
    logic        lp_active;
    logic [1:0]  lp_shift;
    logic [17:0] busy_load;
    logic [7:0]  byte_in;
    logic        wr_byte_ok;
    logic        rd_byte_ok;
    logic        accept;
    logic [7:0]  rd_src;
    logic [6:0]  new_ac;
    logic        exec_cursor;
    logic        exec_cursor_right;
    logic        exec_disp;

    always_comb begin
        lm = st_r.four_line_sel ? LM_FOUR : (st_r.two_line_sel ? LM_TWO : LM_ONE); // R4
    end

    always_comb begin
        st_nxt            = st_r;
        busy              = (st_r.busy_cnt != 18'h00000);
        lp_active         = st_r.low_power_sel & ~extension_driver_pin; // R14
        lp_shift          = !lp_active ? 2'h0 : ((lm == LM_ONE) ? 2'h2 : 2'h1); // R14
        busy_load         = 18'(EXEC_CYCLES) << lp_shift; // R23
        byte_in           = reg_wdata;
        wr_byte_ok        = 1'b0;
        rd_byte_ok        = 1'b0;
        rd_src            = 8'h00;
        new_ac            = st_r.address_counter;
        exec_cursor       = 1'b0;
        exec_cursor_right = 1'b0;
        exec_disp         = 1'b0;
        st_nxt.rdata      = 8'h00;

        if (busy) begin
            st_nxt.busy_cnt = 18'(st_r.busy_cnt - 18'h00001);
        end

        // Inverting cursor phase timer
        if (st_r.cursor_invert) begin // R3
            if (st_r.inv_cnt >= 27'(INV_CYCLES - 1)) begin
                st_nxt.inv_cnt   = 27'h0000000;
                st_nxt.inv_phase = ~st_r.inv_phase;
            end else begin
                st_nxt.inv_cnt = 27'(st_r.inv_cnt + 27'h0000001);
            end
        end else begin
            st_nxt.inv_cnt   = 27'h0000000;
            st_nxt.inv_phase = 1'b0;
        end

        // Reads: status word or prefetched data byte
        if (reg_rd) begin
            rd_src = reg_addr ? st_r.rd_buf : {busy, st_r.address_counter}; // R19
            if (st_r.bus_width_sel) begin // R11
                st_nxt.rdata = rd_src;
                rd_byte_ok   = 1'b1;
            end else if (!st_r.nib_phase) begin
                st_nxt.rdata     = {rd_src[7:4], 4'h0};
                st_nxt.nib_phase = 1'b1;
            end else begin
                st_nxt.rdata     = {rd_src[3:0], 4'h0};
                st_nxt.nib_phase = 1'b0;
                rd_byte_ok       = 1'b1;
            end
        end

        // Writes: in four-bit mode the high nibble arrives first
        if (reg_wr) begin
            if (st_r.bus_width_sel) begin // R11
                wr_byte_ok = 1'b1;
            end else if (!st_r.nib_phase) begin
                st_nxt.nib_hi    = reg_wdata[7:4];
                st_nxt.nib_phase = 1'b1;
            end else begin
                byte_in          = {st_r.nib_hi, reg_wdata[7:4]};
                st_nxt.nib_phase = 1'b0;
                wr_byte_ok       = 1'b1;
            end
        end

        // Completed write bytes are dropped while busy; a data read still returns the buffer but does not step
        accept = wr_byte_ok & ~busy; // R19

        if (accept) begin
            st_nxt.busy_cnt = busy_load;
            if (reg_addr) begin
                unique case (st_r.ram_sel) // R21
                    RS_CG:   st_nxt.user_font_ram[st_r.address_counter[5:0]] = byte_in;
                    RS_SEG:  st_nxt.icon_ram[st_r.address_counter[3:0]] = byte_in;
                    default: st_nxt.char_code_ram[st_r.address_counter] = byte_in;
                endcase
                st_nxt.address_counter = clic_step(st_r.address_counter, st_r.entry_inc, lm, st_r.ram_sel); // R21
                // The read buffer is not refreshed here, so the next read is stale
                if (st_r.ram_sel == RS_DD && st_r.entry_shift && !lp_active) begin // R21
                    st_nxt.disp_offset = clic_pan(st_r.disp_offset, st_r.entry_inc, lm);
                end
            end else if (byte_in[7]) begin
                if (!st_r.ext_reg_enable) begin // R17
                    new_ac                 = byte_in[6:0];
                    st_nxt.address_counter = new_ac;
                    st_nxt.ram_sel         = RS_DD;
                    st_nxt.rd_buf          = clic_ram_read(st_r, RS_DD, new_ac);
                end else begin
                    st_nxt.scroll_qty = byte_in[5:0]; // R18
                end
            end else if (byte_in[6]) begin
                if (!st_r.ext_reg_enable) begin // R15
                    new_ac         = {1'b0, byte_in[5:0]};
                    st_nxt.ram_sel = RS_CG;
                end else begin // R16
                    new_ac         = {3'h0, byte_in[3:0]};
                    st_nxt.ram_sel = RS_SEG;
                end
                st_nxt.address_counter = new_ac;
                st_nxt.rd_buf          = clic_ram_read(st_r, st_nxt.ram_sel, new_ac);
            end else if (byte_in[5]) begin
                st_nxt.bus_width_sel  = byte_in[`CLIC_FS_DL]; // R12
                st_nxt.two_line_sel   = byte_in[`CLIC_FS_N];
                st_nxt.ext_reg_enable = byte_in[`CLIC_FS_RE];
                if (st_r.ext_reg_enable) begin // R12
                    st_nxt.ram_blink_en  = byte_in[`CLIC_FS_BE];
                    st_nxt.low_power_sel = byte_in[`CLIC_FS_LP];
                end
            end else if (byte_in[4]) begin // R23
                if (!st_r.ext_reg_enable) begin
                    st_nxt.ext_reg_enable = 1'b0; // R8
                    if (!byte_in[`CLIC_SH_SC]) begin // R5
                        exec_cursor            = 1'b1;
                        exec_cursor_right      = byte_in[`CLIC_SH_RL];
                        new_ac                 = clic_step(st_r.address_counter, byte_in[`CLIC_SH_RL], lm, RS_DD); // R6
                        st_nxt.address_counter = new_ac;
                        st_nxt.ram_sel         = RS_DD;
                        st_nxt.rd_buf          = clic_ram_read(st_r, RS_DD, new_ac);
                    end else begin
                        exec_disp = 1'b1;
                        if (!lp_active) begin // R9
                            st_nxt.disp_offset = clic_pan(st_r.disp_offset, ~byte_in[`CLIC_SH_RL], lm); // R7
                        end
                    end
                end else begin
                    st_nxt.scroll_line_enables = byte_in[3:0]; // R10
                end
            end else if (byte_in[3]) begin
                if (st_r.ext_reg_enable) begin // R1
                    st_nxt.font_width_sel = byte_in[`CLIC_EF_FW];
                    st_nxt.cursor_invert  = byte_in[`CLIC_EF_BW];
                    st_nxt.four_line_sel  = byte_in[`CLIC_EF_NW];
                end
            end else if (byte_in[2]) begin
                st_nxt.entry_inc   = byte_in[`CLIC_EM_ID];
                st_nxt.entry_shift = byte_in[`CLIC_EM_S];
            end
        end

        // Data read: step address, never shift, prefetch the next byte
        if (rd_byte_ok && reg_addr && !busy) begin // R22
            new_ac                 = clic_step(st_r.address_counter, st_r.entry_inc, lm, st_r.ram_sel);
            st_nxt.address_counter = new_ac;
            st_nxt.rd_buf          = clic_ram_read(st_r, st_r.ram_sel, new_ac);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r               <= '0;
            st_r.bus_width_sel <= `CLIC_RST_DL;
            st_r.entry_inc     <= `CLIC_RST_ID;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = st_r.rdata;

    always_comb begin
        disp.busy_flag           = busy;
        disp.bus_width_sel       = st_r.bus_width_sel;
        disp.font_width_sel      = st_r.font_width_sel;
        disp.rom_left_blank      = st_r.font_width_sel; // R2
        disp.cell_width          = st_r.font_width_sel ? 3'h6 : 3'h5; // R2
        disp.cursor_invert       = st_r.cursor_invert;
        disp.cursor_attr_ignored = st_r.cursor_invert; // R3
        disp.invert_phase        = st_r.inv_phase;
        disp.line_mode           = lm;
        disp.frame_rate_5_6      = st_r.font_width_sel | lp_active; // R2
        disp.ram_blink_en        = st_r.ram_blink_en; // R13
        disp.low_power_active    = lp_active;
        disp.clk_div             = 3'(3'h1 << lp_shift); // R14
        unique case (lm) // R10
            LM_FOUR: disp.scroll_lines = st_r.scroll_line_enables;
            LM_TWO:  disp.scroll_lines = {2'h0, &st_r.scroll_line_enables[3:2], &st_r.scroll_line_enables[1:0]};
            default: disp.scroll_lines = {3'h0, &st_r.scroll_line_enables[1:0]};
        endcase
        // Scrolling is suppressed in low power
        if (lp_active) begin // R9
            disp.scroll_dots = 6'h00;
        end else if (st_r.scroll_qty[5:4] == 2'h3) begin // R18
            disp.scroll_dots = `CLIC_SCROLL_MAX;
        end else begin
            disp.scroll_dots = st_r.scroll_qty;
        end
        disp.disp_offset = st_r.disp_offset;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_EXT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
        !st_r.ext_reg_enable |=> $stable(st_r.font_width_sel) && $stable(st_r.four_line_sel))
        else $error("extension bits changed with extension off");
    AST_SHIFT_CLR_RE: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
        (exec_cursor || exec_disp) |=> !st_r.ext_reg_enable)
        else $error("shift left extension enable set");
    AST_TWO_WRAP: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
        (exec_cursor_right && lm == LM_TWO && st_r.address_counter == 7'h27) |=> st_r.address_counter == 7'h40)
        else $error("cursor did not wrap to second line");
    AST_PURE_SHIFT: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
        exec_disp |=> $stable(st_r.address_counter))
        else $error("display shift moved address");
    AST_BUSY_DROP: assert property (@(posedge core_clk) disable iff (sys_rst) // R19
        (busy && reg_wr) |=> $stable(st_r.address_counter) && $stable(st_r.ext_reg_enable))
        else $error("write accepted while busy");
    AST_BUSY_SET: assert property (@(posedge core_clk) disable iff (sys_rst) // R23
        accept |=> disp.busy_flag)
        else $error("busy not raised after instruction");
    AST_SCROLL_SAT: assert property (@(posedge core_clk) disable iff (sys_rst) // R18
        (st_r.scroll_qty[5:4] == 2'h3 && !lp_active) |-> disp.scroll_dots == 6'h30)
        else $error("scroll did not saturate at 48");
    AST_FOUR_LINE: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
        st_r.four_line_sel |-> disp.line_mode == LM_FOUR)
        else $error("four-line bit not honoured");
    AST_LP_DIV: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
        (lp_active && lm == LM_ONE) |-> disp.clk_div == 3'h4)
        else $error("low power one-line divider wrong");
    AST_NIBBLE: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
        (reg_wr && !st_r.bus_width_sel && !st_r.nib_phase) |=> st_r.nib_phase && $stable(st_r.address_counter))
        else $error("first nibble executed");
    AST_INV_TOGGLE: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
        (st_r.cursor_invert && st_r.inv_cnt == 27'(INV_CYCLES - 1)) |=> st_r.inv_phase != $past(st_r.inv_phase))
        else $error("inverting cursor phase did not toggle");
    AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst) // R19
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");
    AST_LP_NO_SCROLL: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
        lp_active |-> disp.scroll_dots == 6'h00)
        else $error("scroll shown in low power");
    AST_BLINK_HELD: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
        !st_r.ext_reg_enable |=> $stable(st_r.ram_blink_en) && $stable(st_r.low_power_sel))
        else $error("blink or low power changed with extension off");
    AST_READ_STEP: assert property (@(posedge core_clk) disable iff (sys_rst) // R22
        (reg_rd && reg_addr && st_r.bus_width_sel && !busy) |=> st_r.address_counter != $past(st_r.address_counter))
        else $error("data read did not step the address");

endmodule // clic_core

`default_nettype wire

// ==== rtl/clic_defs.svh ====
`ifndef CLIC_DEFS_SVH
`define CLIC_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLIC_CLK_MHZ        250
`define CLIC_EXEC_NS        37000
`define CLIC_EXEC_CYCLES    ((`CLIC_EXEC_NS * `CLIC_CLK_MHZ) / 1000)
`define CLIC_INV_MS         370
`define CLIC_INV_CYCLES     (`CLIC_INV_MS * `CLIC_CLK_MHZ * 1000)

// ****************************************************************
// Instruction field positions
// ****************************************************************
`define CLIC_FS_DL          4
`define CLIC_FS_N           3
`define CLIC_FS_RE          2
`define CLIC_FS_BE          1
`define CLIC_FS_LP          0
`define CLIC_SH_SC          3
`define CLIC_SH_RL          2
`define CLIC_EF_FW          2
`define CLIC_EF_BW          1
`define CLIC_EF_NW          0
`define CLIC_EM_ID          1
`define CLIC_EM_S           0

// ****************************************************************
// Address map of the character RAM per line mode, and the scroll limit
// ****************************************************************
`define CLIC_ONE_END        7'h4F
`define CLIC_TWO_L1_END     7'h27
`define CLIC_TWO_L2_BEG     7'h40
`define CLIC_TWO_L2_END     7'h67
`define CLIC_FOUR_END       5'h13
`define CLIC_LEN_ONE        7'h50
`define CLIC_LEN_TWO        7'h28
`define CLIC_LEN_FOUR       7'h14
`define CLIC_SCROLL_MAX     6'h30

// ****************************************************************
// Reset values
// ****************************************************************
`define CLIC_RST_DL         1'b1
`define CLIC_RST_ID         1'b1

`endif

// ==== rtl/clic_pkg.sv ====
`default_nettype none

package clic_pkg;

    typedef enum logic [1:0] {LM_ONE, LM_TWO, LM_FOUR} clic_line_t;
    typedef enum logic [1:0] {RS_DD, RS_CG, RS_SEG} clic_ram_t;

    typedef struct packed {
        logic                  ext_reg_enable;
        logic                  font_width_sel;
        logic                  cursor_invert;
        logic                  four_line_sel;
        logic                  bus_width_sel;
        logic                  two_line_sel;
        logic                  ram_blink_en;
        logic                  low_power_sel;
        logic                  entry_inc;
        logic                  entry_shift;
        logic [3:0]            scroll_line_enables;
        logic [5:0]            scroll_qty;
        logic [6:0]            address_counter;
        clic_ram_t             ram_sel;
        logic [6:0]            disp_offset;
        logic [17:0]           busy_cnt;
        logic [26:0]           inv_cnt;
        logic                  inv_phase;
        logic                  nib_phase;
        logic [3:0]            nib_hi;
        logic [7:0]            rd_buf;
        logic [7:0]            rdata;
        logic [127:0][7:0]     char_code_ram;
        logic [63:0][7:0]      user_font_ram;
        logic [15:0][7:0]      icon_ram;
    } clic_state_t;

    typedef struct packed {
        logic                  busy_flag;
        logic                  bus_width_sel;
        logic                  font_width_sel;
        logic                  rom_left_blank;
        logic [2:0]            cell_width;
        logic                  cursor_invert;
        logic                  cursor_attr_ignored;
        logic                  invert_phase;
        clic_line_t            line_mode;
        logic                  frame_rate_5_6;
        logic                  ram_blink_en;
        logic                  low_power_active;
        logic [2:0]            clk_div;
        logic [3:0]            scroll_lines;
        logic [5:0]            scroll_dots;
        logic [6:0]            disp_offset;
    } clic_disp_t;

endpackage

`default_nettype wire
